// file: nio_frac_tick.sv
`timescale 1ns/1ps
// fractional rate tick: average rate = clk * step / modulus
module nio_frac_tick #(
    parameter int STEP = 1,
    parameter int MODULUS = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    localparam logic [nio_pkg::ACC_W-1:0] STEP_V = nio_pkg::ACC_W'(STEP);
    localparam logic [nio_pkg::ACC_W-1:0] MOD_V = nio_pkg::ACC_W'(MODULUS);

    logic [nio_pkg::ACC_W-1:0] acc;
    logic [nio_pkg::ACC_W-1:0] sum;
    logic wrap;
    logic [nio_pkg::ACC_W-1:0] next_acc;

    assign sum = acc + STEP_V;
    assign wrap = (sum >= MOD_V);
    assign next_acc = wrap ? (sum - MOD_V) : sum;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= '0;
            tick <= 1'b0;
        end else begin
            acc <= next_acc;
            tick <= wrap;
        end
    end
endmodule

// file: nio_pins_model.sv
`timescale 1ns/1ps
module nio_pins_model (
    input wire logic clk,
    input wire logic [3:0] port_pins_out,
    input wire logic [3:0] port_pins_oe,
    input wire logic [3:0] pd_any,
    input wire logic [3:0] ext_val,
    input wire logic [3:0] ext_drive,
    output logic [3:0] port_pins_in
);
    logic [3:0] float_lvl = 4'h0;
    // undriven pin without pull-down wanders
    always_ff @(posedge clk) begin
        float_lvl <= ~float_lvl;
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (port_pins_oe[i])
                port_pins_in[i] = port_pins_out[i];
            else if (ext_drive[i])
                port_pins_in[i] = ext_val[i];
            else if (pd_any[i])
                port_pins_in[i] = 1'b0;
            else
                port_pins_in[i] = float_lvl[i];
        end
    end
endmodule

// file: nio_pkg.sv
package nio_pkg;
    // register map, 8-bit address, 4-bit data
    localparam int ADDR_W = 8;
    localparam int DATA_W = 4;
    localparam logic [7:0] ADDR_DIRECTION = 8'h02;
    localparam logic [7:0] ADDR_DATA = 8'h03;
    localparam logic [7:0] ADDR_WAKE_EN = 8'h20;
    localparam logic [7:0] ADDR_MEDIUM_PD = 8'h21;
    localparam logic [7:0] ADDR_WEAK_PD = 8'h22;
    localparam logic [7:0] ADDR_OPTIONS = 8'h23;
    localparam logic [7:0] ADDR_CONTROL = 8'h24;
    localparam logic [7:0] ADDR_STATE = 8'h25;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h26;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h27;

    // reset values
    localparam logic [3:0] DIRECTION_RST = 4'h0;
    localparam logic [3:0] DATA_RST = 4'h0;
    localparam logic [3:0] OPT_RST = 4'h0;
    localparam logic [3:0] ZERO4 = 4'h0;

    // options register fields
    localparam int OPT_DUAL_EDGE = 0;
    localparam int OPT_CARRIER = 1;
    localparam int OPT_HIGH_OHM = 2;
    localparam int OPT_AMPLIFIED = 3;

    // control register fields
    localparam int CTL_HALT = 0;
    localparam int CTL_RC_WAKE = 1;

    // state register fields
    localparam int ST_HALT = 0;
    localparam int ST_RC_ACTIVE = 1;

    // interrupt status fields
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_CHANGE = 1;

    // pin roles
    localparam int CARRIER_PIN = 3;
    localparam int ANALOG_PIN = 0;

    // wake-up vector
    localparam int PC_W = 12;
    localparam logic [11:0] WAKE_VECTOR = 12'h004;

    // clock figures in kHz, tick accumulator width in bits
    localparam int SYS_CLK_KHZ = 10000;
    localparam int RC_OSC_KHZ = 32000;
    localparam int CPU_CLK_KHZ = 8192;
    localparam int CARRIER_KHZ = 38;
    localparam int ACC_W = 16;
endpackage

// file: nio_port.sv
`timescale 1ns/1ps
// Behaviour
// - reset from power-on, low-voltage, watchdog
// - reset in halt returns to normal run
// - cpu clock 8.192MHz divided from 10MHz system clock
// - direction register 02H, reset 0000, 1=output
// - data register 03H, inputs read pin
// - outputs drive latch, read returns latch
// - output pins have pull-downs off
// - input pull-downs weak, medium or none
// - halt wake on rising edge, vector 0x004
// - dual-edge option wakes on both edges
// - per-pin wake enables gate wake events
// - high-ohm option turns medium into 220K
// - carrier option gates 38KHz onto pin 3
// - halt forces pin 3 low
// - carrier off makes pin 3 plain I/O
// - amplified wake disables pin-0 pull-downs
// - RC wake buffer enabled by control bit 1 once power-on reset is released
module nio_port (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic low_voltage_reset,
    input wire logic watchdog_timer,
    input wire logic [7:0] addr,
    input wire logic [3:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [3:0] rdata,
    input wire logic [3:0] port_pins_in,
    output logic [3:0] port_pins_out,
    output logic [3:0] port_pins_oe,
    output logic [3:0] weak_pulldown_en,
    output logic [3:0] medium_pulldown_en,
    output logic [3:0] high_ohm_pulldown_en,
    output logic system_reset_n,
    output logic halt_mode,
    output logic osc_restart_req,
    output logic cpu_clk_tick,
    output logic wake_vector_load,
    output logic [11:0] wake_vector,
    output logic rc_wake_buffer_en,
    output logic irq
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // power-on reset release
    logic por_meta;
    logic por_n;
    // system reset
    logic sys_rst_n;
    logic next_sys_rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            por_meta <= 1'b0;
            por_n <= 1'b0;
            sys_rst_n <= 1'b0;
        end else begin
            por_meta <= 1'b1;
            por_n <= por_meta;
            sys_rst_n <= next_sys_rst_n;
        end
    end

    assign next_sys_rst_n = por_n & ~low_voltage_reset & ~watchdog_timer;
    assign system_reset_n = sys_rst_n;

    // clock division
    logic carrier_tick;
    logic carrier;

    nio_frac_tick #(
        .STEP(nio_pkg::CPU_CLK_KHZ),
        .MODULUS(nio_pkg::SYS_CLK_KHZ)
    ) u_cpu_tick (
        .clk(clk),
        .rst_n(sys_rst_n),
        .tick(cpu_clk_tick)
    );

    nio_frac_tick #(
        .STEP(2 * nio_pkg::CARRIER_KHZ),
        .MODULUS(nio_pkg::SYS_CLK_KHZ)
    ) u_carrier_tick (
        .clk(clk),
        .rst_n(sys_rst_n),
        .tick(carrier_tick)
    );

    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            carrier <= 1'b0;
        end else if (carrier_tick) begin
            carrier <= ~carrier;
        end
    end

    // pin input synchroniser
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_level;
    logic [3:0] next_pin_level;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filter
            assign next_pin_level[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_level[gi];
        end
    endgenerate

    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            pin_s1 <= nio_pkg::ZERO4;
            pin_s2 <= nio_pkg::ZERO4;
            pin_s3 <= nio_pkg::ZERO4;
            pin_level <= nio_pkg::ZERO4;
        end else begin
            pin_s1 <= port_pins_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_level <= next_pin_level;
        end
    end

    // register strobes
    logic wr_direction;
    logic wr_data;
    logic wr_wake_en;
    logic wr_medium;
    logic wr_weak;
    logic wr_options;
    logic wr_control;
    logic wr_irq_status;
    logic wr_irq_mask;

    assign wr_direction = wr & hit(addr, nio_pkg::ADDR_DIRECTION);
    assign wr_data = wr & hit(addr, nio_pkg::ADDR_DATA);
    assign wr_wake_en = wr & hit(addr, nio_pkg::ADDR_WAKE_EN);
    assign wr_medium = wr & hit(addr, nio_pkg::ADDR_MEDIUM_PD);
    assign wr_weak = wr & hit(addr, nio_pkg::ADDR_WEAK_PD);
    assign wr_options = wr & hit(addr, nio_pkg::ADDR_OPTIONS);
    assign wr_control = wr & hit(addr, nio_pkg::ADDR_CONTROL);
    assign wr_irq_status = wr & hit(addr, nio_pkg::ADDR_IRQ_STATUS);
    assign wr_irq_mask = wr & hit(addr, nio_pkg::ADDR_IRQ_MASK);

    // registers
    logic [3:0] port_direction;
    logic [3:0] port_data;
    logic [3:0] pin_wake_enable_opt;
    logic [3:0] medium_pulldown_opt;
    logic [3:0] weak_pulldown_opt;
    logic [3:0] options;
    logic rc_wake_opt;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;

    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            port_direction <= nio_pkg::DIRECTION_RST;
            port_data <= nio_pkg::DATA_RST;
            pin_wake_enable_opt <= nio_pkg::OPT_RST;
            medium_pulldown_opt <= nio_pkg::OPT_RST;
            weak_pulldown_opt <= nio_pkg::OPT_RST;
            options <= nio_pkg::OPT_RST;
            irq_mask <= nio_pkg::OPT_RST;
        end else begin
            if (wr_direction) begin
                port_direction <= wdata;
            end
            if (wr_data) begin
                port_data <= wdata;
            end
            if (wr_wake_en) begin
                pin_wake_enable_opt <= wdata;
            end
            if (wr_medium) begin
                medium_pulldown_opt <= wdata;
            end
            if (wr_weak) begin
                weak_pulldown_opt <= wdata;
            end
            if (wr_options) begin
                options <= wdata;
            end
            if (wr_irq_mask) begin
                irq_mask <= wdata;
            end
        end
    end

    // rc wake option lives across system resets, cleared only at power-on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rc_wake_opt <= 1'b0;
            rc_wake_buffer_en <= 1'b0;
        end else begin
            if (wr_control) begin
                rc_wake_opt <= wdata[nio_pkg::CTL_RC_WAKE];
            end
            rc_wake_buffer_en <= por_n & rc_wake_opt;
        end
    end

    logic dual_edge_wake_opt;
    logic carrier_output_opt;
    logic high_ohm_pulldown_opt;
    logic amplified_wake_opt;

    assign dual_edge_wake_opt = options[nio_pkg::OPT_DUAL_EDGE];
    assign carrier_output_opt = options[nio_pkg::OPT_CARRIER];
    assign high_ohm_pulldown_opt = options[nio_pkg::OPT_HIGH_OHM];
    assign amplified_wake_opt = options[nio_pkg::OPT_AMPLIFIED];

    // halt and wake
    logic halt;
    logic next_halt;
    logic [3:0] halt_snapshot;
    logic [3:0] raw_rise;
    logic [3:0] raw_fall;
    logic [3:0] sync_rise;
    logic [3:0] sync_fall;
    logic wake_async;
    logic wake_sync;
    logic enter_halt;

    assign enter_halt = wr_control & wdata[nio_pkg::CTL_HALT] & ~halt;
    assign raw_rise = port_pins_in & ~halt_snapshot;
    assign raw_fall = ~port_pins_in & halt_snapshot;
    assign sync_rise = pin_level & ~halt_snapshot;
    assign sync_fall = ~pin_level & halt_snapshot;
    // clockless path to restart the stopped oscillator
    assign wake_async = halt & |(pin_wake_enable_opt & (raw_rise | (raw_fall & {4{dual_edge_wake_opt}})));
    assign wake_sync = halt & |(pin_wake_enable_opt & (sync_rise | (sync_fall & {4{dual_edge_wake_opt}})));
    assign next_halt = enter_halt | (halt & ~wake_sync);
    assign osc_restart_req = wake_async;
    assign halt_mode = halt;

    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            halt <= 1'b0;
            halt_snapshot <= nio_pkg::ZERO4;
            wake_vector_load <= 1'b0;
            wake_vector <= '0;
        end else begin
            halt <= next_halt;
            if (enter_halt) begin
                halt_snapshot <= pin_level;
            end
            wake_vector_load <= wake_sync;
            wake_vector <= nio_pkg::WAKE_VECTOR;
        end
    end

    // interrupt status, set wins over write-one clear
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic [3:0] next_irq_status;
    logic [3:0] input_change;

    assign input_change = (next_pin_level ^ pin_level) & ~port_direction;
    assign irq_set = {2'h0, |input_change, wake_sync};
    assign irq_clr = wr_irq_status ? wdata : nio_pkg::ZERO4;
    assign next_irq_status = irq_set | (irq_status & ~irq_clr);
    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            irq_status <= nio_pkg::ZERO4;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // pin drive and pull-downs
    logic [3:0] next_pins_out;
    logic [3:0] next_weak;
    logic [3:0] next_medium;
    logic [3:0] next_high_ohm;
    logic [3:0] analog_mask;
    logic pin3_value;

    assign pin3_value = halt ? 1'b0 :
        carrier_output_opt ? (port_data[nio_pkg::CARRIER_PIN] & carrier) :
        port_data[nio_pkg::CARRIER_PIN];
    assign next_pins_out = {pin3_value, port_data[2:0]};
    assign analog_mask = {3'h0, amplified_wake_opt} << nio_pkg::ANALOG_PIN;
    // output pins never pull down; amplified wake frees pin 0
    assign next_weak = weak_pulldown_opt & ~port_direction & ~analog_mask;
    assign next_medium = medium_pulldown_opt & ~port_direction & ~analog_mask & ~{4{high_ohm_pulldown_opt}};
    assign next_high_ohm = medium_pulldown_opt & ~port_direction & ~analog_mask & {4{high_ohm_pulldown_opt}};

    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            port_pins_out <= nio_pkg::ZERO4;
            port_pins_oe <= nio_pkg::ZERO4;
            weak_pulldown_en <= nio_pkg::ZERO4;
            medium_pulldown_en <= nio_pkg::ZERO4;
            high_ohm_pulldown_en <= nio_pkg::ZERO4;
        end else begin
            port_pins_out <= next_pins_out;
            port_pins_oe <= port_direction;
            weak_pulldown_en <= next_weak;
            medium_pulldown_en <= next_medium;
            high_ohm_pulldown_en <= next_high_ohm;
        end
    end

    // read path, one cycle after the strobe
    logic [3:0] data_view;
    logic [3:0] state_view;
    logic [3:0] control_view;
    logic [3:0] next_rdata;

    assign data_view = (port_direction & port_data) | (~port_direction & pin_level);
    assign state_view = {2'h0, rc_wake_buffer_en, halt};
    assign control_view = {2'h0, rc_wake_opt, halt};

    always_comb begin
        next_rdata = nio_pkg::ZERO4;
        if (rd) begin
            case (addr)
                nio_pkg::ADDR_DIRECTION: next_rdata = port_direction;
                nio_pkg::ADDR_DATA: next_rdata = data_view;
                nio_pkg::ADDR_WAKE_EN: next_rdata = pin_wake_enable_opt;
                nio_pkg::ADDR_MEDIUM_PD: next_rdata = medium_pulldown_opt;
                nio_pkg::ADDR_WEAK_PD: next_rdata = weak_pulldown_opt;
                nio_pkg::ADDR_OPTIONS: next_rdata = options;
                nio_pkg::ADDR_CONTROL: next_rdata = control_view;
                nio_pkg::ADDR_STATE: next_rdata = state_view;
                nio_pkg::ADDR_IRQ_STATUS: next_rdata = irq_status;
                nio_pkg::ADDR_IRQ_MASK: next_rdata = irq_mask;
                default: next_rdata = nio_pkg::ZERO4;
            endcase
        end
    end

    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            rdata <= nio_pkg::ZERO4;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule

// file: nio_port_assertions.sv
`timescale 1ns/1ps
module nio_port_assertions (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic low_voltage_reset,
    input wire logic watchdog_timer,
    input wire logic [7:0] addr,
    input wire logic [3:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [3:0] rdata,
    input wire logic [3:0] port_pins_out,
    input wire logic [3:0] port_pins_oe,
    input wire logic [3:0] weak_pulldown_en,
    input wire logic [3:0] medium_pulldown_en,
    input wire logic [3:0] high_ohm_pulldown_en,
    input wire logic system_reset_n,
    input wire logic halt_mode,
    input wire logic cpu_clk_tick,
    input wire logic wake_vector_load,
    input wire logic [11:0] wake_vector
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n || !system_reset_n);
    sequence s_dir_write;
        wr && addr == nio_pkg::ADDR_DIRECTION ##1 !wr;
    endsequence
    sequence s_wake_exit;
        $fell(halt_mode) ##1 !wake_vector_load;
    endsequence
    a_dir_to_oe: assert property (s_dir_write |=> port_pins_oe == $past(wdata, 2))
        else $error("direction write not seen on output enables");
    a_dir_readback: assert property (rd && addr == nio_pkg::ADDR_DIRECTION |=> rdata == port_pins_oe)
        else $error("direction read differs from output enables");
    a_read_idle: assert property (!$past(rd) |-> rdata == 4'h0)
        else $error("read data outside the read slot");
    a_read_unmapped: assert property (rd && addr == 8'h10 |=> rdata == 4'h0)
        else $error("unmapped read returned data");
    a_pd_out_off: assert property ((port_pins_oe & (weak_pulldown_en | medium_pulldown_en
        | high_ohm_pulldown_en)) == 4'h0)
        else $error("pull-down on an output pin");
    a_high_med_excl: assert property ((medium_pulldown_en & high_ohm_pulldown_en) == 4'h0)
        else $error("medium and high-ohm pull-down together");
    a_halt_pin3_low: assert property (halt_mode && $past(halt_mode) |-> !port_pins_out[3])
        else $error("pin 3 driven high in halt");
    a_wake_pulse: assert property (wake_vector_load |-> s_wake_exit)
        else $error("wake load pulse not tied to halt exit");
    a_wake_vec: assert property (wake_vector_load |-> wake_vector == nio_pkg::WAKE_VECTOR)
        else $error("wrong wake vector");
    a_tick_gap: assert property (!cpu_clk_tick && $past(system_reset_n, 2) |=> cpu_clk_tick)
        else $error("cpu tick rate too low");
    a_sys_reset: assert property (@(posedge clk) disable iff (!reset_n)
        (low_voltage_reset || watchdog_timer) |=> !system_reset_n)
        else $error("system reset not asserted");
endmodule
bind nio_port nio_port_assertions nio_port_assertions_inst (.clk, .reset_n, .low_voltage_reset,
    .watchdog_timer, .addr, .wdata, .wr, .rd, .rdata, .port_pins_out, .port_pins_oe, .weak_pulldown_en,
    .medium_pulldown_en, .high_ohm_pulldown_en, .system_reset_n, .halt_mode, .cpu_clk_tick,
    .wake_vector_load, .wake_vector);

// file: tb_nibble_io_port_wake.sv
`timescale 1ns/1ps
module tb_nibble_io_port_wake;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic low_voltage_reset = 1'b0;
    logic watchdog_timer = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] wdata = 4'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] ext_val = 4'h0;
    logic [3:0] ext_drive = 4'hF;
    logic [3:0] rdata, port_pins_in, port_pins_out, port_pins_oe;
    logic [3:0] weak_pulldown_en, medium_pulldown_en, high_ohm_pulldown_en;
    logic system_reset_n, halt_mode, osc_restart_req, cpu_clk_tick, wake_vector_load, rc_wake_buffer_en, irq;
    logic [11:0] wake_vector;
    logic [3:0] dir, dat, ext, wk, md, v;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;
    nio_port nio_port_inst (.clk, .reset_n, .low_voltage_reset, .watchdog_timer, .addr, .wdata, .wr, .rd,
        .rdata, .port_pins_in, .port_pins_out, .port_pins_oe, .weak_pulldown_en, .medium_pulldown_en,
        .high_ohm_pulldown_en, .system_reset_n, .halt_mode, .osc_restart_req, .cpu_clk_tick,
        .wake_vector_load, .wake_vector, .rc_wake_buffer_en, .irq);
    nio_pins_model nio_pins_model_inst (.clk, .port_pins_out, .port_pins_oe,
        .pd_any(weak_pulldown_en | medium_pulldown_en | high_ohm_pulldown_en),
        .ext_val, .ext_drive, .port_pins_in);
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [3:0] exp_data(input logic [3:0] d, input logic [3:0] q, input logic [3:0] e);
        return (q & d) | (e & ~d);
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [3:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [3:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic edges(input int k, output int cnt);
        logic prev;
        cnt = 0;
        prev = port_pins_out[3];
        repeat (k) begin
            @(posedge clk);
            #1;
            if (port_pins_out[3] && !prev)
                cnt++;
            prev = port_pins_out[3];
        end
    endtask
    task automatic wake_try(input logic [3:0] opt, input logic [3:0] en, input logic [3:0] s,
        input logic [3:0] f, input logic exp);
        logic woke;
        wr_reg(nio_pkg::ADDR_OPTIONS, opt);
        wr_reg(nio_pkg::ADDR_WAKE_EN, en);
        ext_val <= s;
        cyc(6);
        wr_reg(nio_pkg::ADDR_CONTROL, 4'h3);
        cyc(3);
        chk("halt", {3'h0, halt_mode}, 4'h1);
        chk("pin3_halt", {3'h0, port_pins_out[3]}, 4'h0);
        @(posedge clk);
        ext_val <= f;
        #1;
        chk("osc_req", {3'h0, osc_restart_req}, {3'h0, exp});
        woke = 1'b0;
        repeat (12) begin
            @(posedge clk);
            #1;
            woke |= wake_vector_load;
        end
        chk("woke", {3'h0, woke}, {3'h0, exp});
        chk("halt_left", {3'h0, halt_mode}, {3'h0, !exp});
    endtask
    initial begin
        void'($urandom(32'hEC14EF25));
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        cyc(4);
        rd_reg(nio_pkg::ADDR_DIRECTION, v);
        chk("dir_reset", v, 4'h0);
        rd_reg(8'h10, v);
        chk("unmapped", v, 4'h0);
        for (int i = 0; i < 8; i++) begin
            dir = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
            dat = 4'($urandom);
            ext = 4'($urandom);
            wk = 4'($urandom);
            md = 4'($urandom);
            wr_reg(nio_pkg::ADDR_DIRECTION, dir);
            wr_reg(nio_pkg::ADDR_DATA, dat);
            wr_reg(nio_pkg::ADDR_WEAK_PD, wk);
            wr_reg(nio_pkg::ADDR_MEDIUM_PD, md);
            ext_drive <= ~dir;
            ext_val <= ext;
            cyc(8);
            rd_reg(nio_pkg::ADDR_DATA, v);
            chk("data_read", v, exp_data(dir, dat, ext));
            chk("pins_out", port_pins_out & dir, dat & dir);
            chk("pins_oe", port_pins_oe, dir);
            chk("weak_pd", weak_pulldown_en, wk & ~dir);
            chk("medium_pd", medium_pulldown_en, md & ~dir);
        end
        wr_reg(nio_pkg::ADDR_DIRECTION, 4'h0);
        ext_drive <= 4'hF;
        wr_reg(nio_pkg::ADDR_WEAK_PD, 4'hF);
        wr_reg(nio_pkg::ADDR_MEDIUM_PD, 4'hF);
        wr_reg(nio_pkg::ADDR_OPTIONS, 4'hC);
        cyc(4);
        chk("weak_amp", weak_pulldown_en, 4'hE);
        chk("medium_high", medium_pulldown_en, 4'h0);
        chk("high_pd", high_ohm_pulldown_en, 4'hE);
        wr_reg(nio_pkg::ADDR_DIRECTION, 4'h8);
        ext_drive <= 4'h7;
        wr_reg(nio_pkg::ADDR_DATA, 4'h8);
        wr_reg(nio_pkg::ADDR_OPTIONS, 4'h2);
        edges(2632, n);
        chk("carrier_on", {3'h0, n inside {[9:11]}}, 4'h1);
        wr_reg(nio_pkg::ADDR_DATA, 4'h0);
        cyc(2);
        edges(600, n);
        chk("carrier_low", {3'h0, n == 0 && !port_pins_out[3]}, 4'h1);
        wr_reg(nio_pkg::ADDR_DATA, 4'h8);
        wr_reg(nio_pkg::ADDR_IRQ_MASK, 4'h0);
        wr_reg(nio_pkg::ADDR_CONTROL, 4'h2);
        cyc(3);
        chk("rc_buffer", {3'h0, rc_wake_buffer_en}, 4'h1);
        wake_try(4'h0, 4'h1, 4'h0, 4'h1, 1'b1);
        chk("irq_masked", {3'h0, irq}, 4'h0);
        wr_reg(nio_pkg::ADDR_IRQ_MASK, 4'h1);
        cyc(1);
        chk("irq_on", {3'h0, irq}, 4'h1);
        rd_reg(nio_pkg::ADDR_IRQ_STATUS, v);
        chk("wake_status", v, 4'h3);
        wr_reg(nio_pkg::ADDR_IRQ_STATUS, 4'h3);
        cyc(2);
        chk("irq_clear", {3'h0, irq}, 4'h0);
        wake_try(4'h1, 4'h4, 4'h7, 4'h3, 1'b1);
        wake_try(4'h0, 4'h1, 4'h1, 4'h6, 1'b0);
        rd_reg(nio_pkg::ADDR_STATE, v);
        chk("state_halt", v, 4'h3);
        @(posedge clk);
        watchdog_timer <= 1'b1;
        cyc(2);
        chk("wdt_reset", {3'h0, system_reset_n}, 4'h0);
        @(posedge clk);
        watchdog_timer <= 1'b0;
        cyc(4);
        chk("halt_reset", {1'b0, halt_mode, system_reset_n, rc_wake_buffer_en}, 4'h3);
        rd_reg(nio_pkg::ADDR_DIRECTION, v);
        chk("dir_sysreset", v, 4'h0);
        @(posedge clk);
        low_voltage_reset <= 1'b1;
        cyc(2);
        chk("lvr_reset", {3'h0, system_reset_n}, 4'h0);
        @(posedge clk);
        low_voltage_reset <= 1'b0;
        cyc(4);
        final_report();
    end
endmodule
